// ---- logic/tcm_defs.vh ----
// Purpose: Constants for the channel 2 output-compare block
// Assumes: 32-bit register data path, 16-bit registers in the low half
// Notes: Offsets are byte addresses
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

// Register offsets
`define TCM_ADDR_CTRL 8'h18
`define TCM_ADDR_CMP 8'h38
`define TCM_ADDR_POL 8'h40
`define TCM_ADDR_STAT 8'h44

// Control register fields
`define TCM_CLR_EN_BIT 15
`define TCM_MODE_HI 14
`define TCM_MODE_LO 12
`define TCM_PRELOAD_BIT 11
`define TCM_DIR_HI 9
`define TCM_DIR_LO 8

// Polarity register fields
`define TCM_POL_MAIN_BIT 0
`define TCM_POL_COMP_BIT 1
`define TCM_POL_CLR_MATCH_BIT 8

// Status register fields
`define TCM_STAT_REF_BIT 0
`define TCM_STAT_MAIN_BIT 1
`define TCM_STAT_COMP_BIT 2
`define TCM_STAT_MATCH_BIT 3
`define TCM_STAT_OUTDIR_BIT 4

// Reset values
`define TCM_CTRL_RST 16'h0000
`define TCM_CMP_RST 16'h0000
`define TCM_POL_RST 2'h0

// Direction select value for output
`define TCM_DIR_OUTPUT 2'h0

// Mode encodings
`define TCM_MODE_FROZEN 3'h0
`define TCM_MODE_SET 3'h1
`define TCM_MODE_CLEAR 3'h2
`define TCM_MODE_TOGGLE 3'h3
`define TCM_MODE_LOW 3'h4
`define TCM_MODE_HIGH 3'h5
`define TCM_MODE_PWM1 3'h6
`define TCM_MODE_PWM2 3'h7

`endif

// ---- logic/tcm_sync3.v ----
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output follows once stages two and three agree
module tcm_sync3 (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Signal
  input wire din,
  output reg dout
);

  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        dout <= stage3;
      end
    end
  end

endmodule

// ---- logic/tcm_ch2_compare.v ----
// Purpose: Channel 2 output-compare logic of an advanced timer
// Assumes: Core counter, count direction and update event come from
//   the timer on the same clock; the external trigger is asynchronous
// Notes: Register port with read data one cycle after the read strobe
//
// Summary of operation
// - Direction field decides input or output meaning
// - Clear enable: trigger high forces reference low
// - Mode field drives reference; polarity shapes outputs
// - Mode 000: match leaves reference unchanged
// - Mode 001: match drives reference high
// - Mode 010: match drives reference low
// - Mode 011: match toggles reference
// - Mode 100: reference forced low
// - Mode 101: reference forced high
// - Mode 110: first pulse-width rule by direction
// - Preload enable shadows compare until update
// - Direction 00 makes channel an output
`include "tcm_defs.vh"

module tcm_ch2_compare (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdData,
  // Timer core
  input wire [15:0] coreCount,
  input wire countDown,
  input wire updateEvent,
  // External trigger, asynchronous
  input wire external_trigger_filtered,
  // Channel outputs
  output reg ch2_output_reference,
  output wire ch2_main_output,
  output wire ch2_complement_output,
  output wire ch2OutputMode
);

  // Reset release
  reg rstSync1;
  reg rstSync2;
  wire rstN;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  assign rstN = rstSync2;

  // External trigger synchronised
  // Clear reaches the reference five edges after the pin
  wire trigSync;

  tcm_sync3 u_trig_sync (
    .clk(clk),
    .rstN(rstN),
    .din(external_trigger_filtered),
    .dout(trigSync)
  );

  // Registers
  reg [15:0] channel_pair_control_one;
  reg [15:0] cmpPreload;
  reg [15:0] cmpActive;
  reg [1:0] polarity;
  reg matchSeen;

  // Control fields
  wire ch2_ref_clear_enable;
  wire [2:0] ch2_output_mode;
  wire ch2_compare_preload_enable;
  wire [1:0] ch2_direction_select;
  wire ch2_main_polarity;
  wire ch2_complement_polarity;

  assign ch2_ref_clear_enable = channel_pair_control_one[`TCM_CLR_EN_BIT];
  assign ch2_output_mode = channel_pair_control_one[`TCM_MODE_HI:`TCM_MODE_LO];
  assign ch2_compare_preload_enable = channel_pair_control_one[`TCM_PRELOAD_BIT];
  assign ch2_direction_select = channel_pair_control_one[`TCM_DIR_HI:`TCM_DIR_LO];
  assign ch2_main_polarity = polarity[`TCM_POL_MAIN_BIT];
  assign ch2_complement_polarity = polarity[`TCM_POL_COMP_BIT];

  // Address decode
  function isAddr;
    input [7:0] addr;
    input [7:0] target;
    begin
      isAddr = (addr == target);
    end
  endfunction

  wire wrCtrl;
  wire wrCmp;
  wire wrPol;

  assign wrCtrl = regWrite && isAddr(regAddr, `TCM_ADDR_CTRL);
  assign wrCmp = regWrite && isAddr(regAddr, `TCM_ADDR_CMP);
  assign wrPol = regWrite && isAddr(regAddr, `TCM_ADDR_POL);

  // Write-one clear of the sticky match flag
  wire clrMatch;

  assign clrMatch = wrPol && regWrData[`TCM_POL_CLR_MATCH_BIT];

  // Channel is an output only with direction 00
  assign ch2OutputMode = (ch2_direction_select == `TCM_DIR_OUTPUT);

  // Control and polarity registers
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      channel_pair_control_one <= `TCM_CTRL_RST;
      polarity <= `TCM_POL_RST;
    end else begin
      if (wrCtrl) begin
        channel_pair_control_one <= regWrData[15:0];
      end
      if (wrPol) begin
        polarity <= regWrData[1:0];
      end
    end
  end

  // Compare value, preload copy and active shadow
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cmpPreload <= `TCM_CMP_RST;
      cmpActive <= `TCM_CMP_RST;
    end else begin
      if (wrCmp) begin
        cmpPreload <= regWrData[15:0];
      end
      // Write beside an update with preload on: active takes the old preload
      if (!ch2_compare_preload_enable) begin
        if (wrCmp) begin
          cmpActive <= regWrData[15:0];
        end
      end else if (updateEvent) begin
        cmpActive <= cmpPreload;
      end
    end
  end

  // Comparison against the core counter
  wire countMatch;
  wire countAbove;

  assign countMatch = (coreCount == cmpActive);
  assign countAbove = (coreCount > cmpActive);

  // First pulse-width level
  function pwmOneLevel;
    input down;
    input above;
    begin
      if (down) begin
        pwmOneLevel = above;
      end else begin
        pwmOneLevel = !above;
      end
    end
  endfunction

  // Reference next value
  reg next_ref;

  always @* begin
    next_ref = ch2_output_reference;
    if (!ch2OutputMode) begin
      // Input direction: reference parked low
      next_ref = 1'b0;
    end else if (ch2_ref_clear_enable && trigSync) begin
      next_ref = 1'b0;
    end else begin
      case (ch2_output_mode)
        `TCM_MODE_FROZEN: begin
          next_ref = ch2_output_reference;
        end
        `TCM_MODE_SET: begin
          if (countMatch) begin
            next_ref = 1'b1;
          end
        end
        `TCM_MODE_CLEAR: begin
          if (countMatch) begin
            next_ref = 1'b0;
          end
        end
        `TCM_MODE_TOGGLE: begin
          if (countMatch) begin
            next_ref = !ch2_output_reference;
          end
        end
        `TCM_MODE_LOW: begin
          next_ref = 1'b0;
        end
        `TCM_MODE_HIGH: begin
          next_ref = 1'b1;
        end
        `TCM_MODE_PWM1: begin
          next_ref = pwmOneLevel(countDown, countAbove);
        end
        `TCM_MODE_PWM2: begin
          next_ref = !pwmOneLevel(countDown, countAbove);
        end
        default: begin
          next_ref = ch2_output_reference;
        end
      endcase
    end
  end

  // Reference and match flag
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ch2_output_reference <= 1'b0;
      matchSeen <= 1'b0;
    end else begin
      ch2_output_reference <= next_ref;
      // Set wins over a write-one clear in the same cycle
      if (ch2OutputMode && countMatch) begin
        matchSeen <= 1'b1;
      end else if (clrMatch) begin
        matchSeen <= 1'b0;
      end
    end
  end

  // Polarity: complement starts from the inverted reference; each output XORs its polarity bit
  wire [1:0] outLevel;
  wire [1:0] refLevel;

  assign refLevel = {!ch2_output_reference, ch2_output_reference};

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_pol
      assign outLevel[i] = refLevel[i] ^ polarity[i];
    end
  endgenerate

  assign ch2_main_output = outLevel[`TCM_POL_MAIN_BIT];
  assign ch2_complement_output = outLevel[`TCM_POL_COMP_BIT];

  // Status word
  reg [15:0] statusWord;

  always @* begin
    statusWord = 16'h0000;
    statusWord[`TCM_STAT_REF_BIT] = ch2_output_reference;
    statusWord[`TCM_STAT_MAIN_BIT] = ch2_main_output;
    statusWord[`TCM_STAT_COMP_BIT] = ch2_complement_output;
    statusWord[`TCM_STAT_MATCH_BIT] = matchSeen;
    statusWord[`TCM_STAT_OUTDIR_BIT] = ch2OutputMode;
  end

  // Read data, one cycle after the strobe
  reg [15:0] next_rd;

  always @* begin
    next_rd = 16'h0000;
    case (regAddr)
      `TCM_ADDR_CTRL: begin
        next_rd = channel_pair_control_one;
      end
      `TCM_ADDR_CMP: begin
        next_rd = cmpPreload;
      end
      `TCM_ADDR_POL: begin
        next_rd = {14'h0000, ch2_complement_polarity, ch2_main_polarity};
      end
      `TCM_ADDR_STAT: begin
        next_rd = statusWord;
      end
      default: begin
        next_rd = 16'h0000;
      end
    endcase
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      regRdData <= {16'h0000, next_rd};
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

endmodule

// ---- verification/tcm_ch2_compare_chk.sv ----
// Purpose: Port-level checks of the channel 2 output-compare block
// Assumes: Control, compare and polarity are mirrored from register writes
// Notes: Trigger checks assume clear enable held throughout
`include "tcm_defs.vh"

module tcm_ch2_compare_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  // Timer core and trigger
  input wire logic [15:0] coreCount,
  input wire logic countDown,
  input wire logic updateEvent,
  input wire logic external_trigger_filtered,
  // Outputs
  input wire logic ch2_output_reference,
  input wire logic ch2_main_output,
  input wire logic ch2_complement_output,
  input wire logic ch2OutputMode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] ctl, pre, act;
  logic [1:0] pol;
  wire [2:0] m = ctl[14:12];
  wire live = ch2OutputMode && !ctl[15];
  wire hit = live && coreCount == act;
  wire gt = coreCount > act;
  wire pwmRef = m[0] ^ (countDown ? gt : !gt);
  wire wr = regWrite;

  // Mirror of the software-visible state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 16'h0000;
      pre <= 16'h0000;
      act <= 16'h0000;
      pol <= 2'h0;
    end else begin
      if (wr && regAddr == `TCM_ADDR_CTRL) ctl <= regWrData[15:0];
      if (wr && regAddr == `TCM_ADDR_POL) pol <= regWrData[1:0];
      if (wr && regAddr == `TCM_ADDR_CMP) pre <= regWrData[15:0];
      if (wr && regAddr == `TCM_ADDR_CMP && !ctl[11]) act <= regWrData[15:0];
      else if (updateEvent && ctl[11]) act <= pre;
    end
  end

  a_main_polarity: assert property (ch2_main_output == (ch2_output_reference ^ pol[0]))
    else $error("main output level wrong");
  a_comp_polarity: assert property (ch2_complement_output == (!ch2_output_reference ^ pol[1]))
    else $error("complement output level wrong");
  a_out_direction: assert property (ch2OutputMode == (ctl[9:8] == 2'h0))
    else $error("output direction flag wrong");
  a_input_park: assert property (!ch2OutputMode |=> !ch2_output_reference)
    else $error("reference active in input direction");
  a_frozen_hold: assert property (live && m == 3'h0 |=> $stable(ch2_output_reference))
    else $error("frozen reference moved");
  a_match_set: assert property (hit && m == 3'h1 |=> ch2_output_reference)
    else $error("match did not set reference");
  a_match_clear: assert property (hit && m == 3'h2 |=> !ch2_output_reference)
    else $error("match did not clear reference");
  a_match_toggle: assert property (hit && m == 3'h3 |=> $changed(ch2_output_reference))
    else $error("match did not toggle reference");
  a_force_low: assert property (ch2OutputMode && m == 3'h4 |=> !ch2_output_reference)
    else $error("forced low failed");
  a_force_high: assert property (live && m == 3'h5 |=> ch2_output_reference)
    else $error("forced high failed");
  a_pwm_level: assert property (live && m[2:1] == 2'h3 |=> ch2_output_reference == $past(pwmRef))
    else $error("pulse-width level wrong");
  a_trig_clear: assert property ((ctl[15] && external_trigger_filtered)[*7] |-> !ch2_output_reference)
    else $error("trigger did not clear reference");
  c_toggle: cover property (hit && m == 3'h3);
  c_pwm_down: cover property (live && m == 3'h7 && countDown);
  c_trig: cover property (ctl[15] && external_trigger_filtered);
endmodule

bind tcm_ch2_compare tcm_ch2_compare_chk i_tcm_ch2_compare_chk (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .coreCount(coreCount), .countDown(countDown), .updateEvent(updateEvent),
  .external_trigger_filtered(external_trigger_filtered),
  .ch2_output_reference(ch2_output_reference), .ch2_main_output(ch2_main_output),
  .ch2_complement_output(ch2_complement_output), .ch2OutputMode(ch2OutputMode)
);

// ---- verification/tcm_ch2_compare_tb.sv ----
// Purpose: Directed register-level test of the channel 2 output-compare block
// Assumes: Reference is registered one cycle after the counter value
// Notes: Counter is held at a match value for one cycle only
module tcm_ch2_compare_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic countDown = 1'b0, updateEvent = 1'b0, trig = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic [15:0] coreCount = 16'h0000;
  wire [31:0] regRdData;
  wire refOut, mainOut, compOut, outMode;
  int error_cnt = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  tcm_ch2_compare i_tcm_ch2_compare (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .coreCount(coreCount), .countDown(countDown), .updateEvent(updateEvent),
    .external_trigger_filtered(trig), .ch2_output_reference(refOut),
    .ch2_main_output(mainOut), .ch2_complement_output(compOut), .ch2OutputMode(outMode)
  );

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= {16'h0000, d};
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk("readData", regRdData, {16'h0000, e});
  endtask

  // Write control, show one counter value, check reference
  task automatic step(logic [15:0] c, logic [15:0] n, logic e);
    wr(8'h18, c);
    coreCount <= n;
    @(posedge clk);
    coreCount <= 16'h0000;
    #1 chk("reference", refOut, e);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h18, 16'h0000);
    chk("reference", refOut, 0);
    chk("complement", compOut, 1);
    chk("outMode", outMode, 1);
    rd(8'h7C, 16'h0000);
    $display("test reset done");
    wr(8'h38, 16'h0005);
    step(16'h5000, 16'h0005, 1);
    step(16'h2000, 16'h0005, 0);
    step(16'h1000, 16'h0005, 1);
    step(16'h3000, 16'h0005, 0);
    step(16'h3000, 16'h0005, 1);
    step(16'h0000, 16'h0005, 1);
    step(16'h4000, 16'h0005, 0);
    step(16'h1000, 16'h0004, 0);
    step(16'h6000, 16'h0006, 0);
    step(16'h6000, 16'h0004, 1);
    @(posedge clk);
    countDown <= 1'b1;
    step(16'h6000, 16'h0006, 1);
    step(16'h7000, 16'h0006, 0);
    step(16'h6000, 16'h0004, 0);
    @(posedge clk);
    countDown <= 1'b0;
    $display("test modes done");
    step(16'h5000, 16'h0000, 1);
    wr(8'h40, 16'h0003);
    #1 chk("main", mainOut, 0);
    chk("complement", compOut, 1);
    wr(8'h40, 16'h0000);
    $display("test polarity done");
    wr(8'h18, 16'hA800);
    wr(8'h38, 16'h0009);
    step(16'hA800, 16'h0009, 1);
    @(posedge clk);
    updateEvent <= 1'b1;
    @(posedge clk);
    updateEvent <= 1'b0;
    step(16'hA800, 16'h0009, 0);
    rd(8'h38, 16'h0009);
    rd(8'h18, 16'hA800);
    $display("test preload done");
    step(16'h5000, 16'h0000, 1);
    @(posedge clk);
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("reference", refOut, 1);
    wr(8'h18, 16'hD000);
    repeat (8) @(posedge clk);
    #1 chk("reference", refOut, 0);
    @(posedge clk);
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("reference", refOut, 1);
    $display("test clear done");
    wr(8'h18, 16'h5100);
    @(posedge clk);
    #1 chk("reference", refOut, 0);
    chk("outMode", outMode, 0);
    rd(8'h18, 16'h5100);
    $display("test direction done");
    rd(8'h44, 16'h000C);
    wr(8'h40, 16'h0100);
    rd(8'h44, 16'h0004);
    rd(8'h40, 16'h0000);
    $display("test status done");
    stop_test();
  end
endmodule
